// ==== motor_lock_fault_supervisor.sv ====
//------------------------------------------------------------------------------
// Purpose: lock and no-motor supervision, fault retry, surge clamp, pwm
// Assumes: motor-side inputs synchronous to hclk, one ahb-lite slave
// Notes:   ce low freezes all state and stalls the bus
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module motor_lock_fault_supervisor #(
	parameter int LOCK_OFF_CYCLES  = motor_lock_pkg::LOCK_OFF_DEF,
	parameter int ABN_SPEED_CYCLES = motor_lock_pkg::ABN_SPEED_DEF
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	// ahb-lite slave
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic      [31:0]      hrdata,
	// motor sensing and sequencer
	input  wire logic [11:0]      lowside_current_ma,
	input  wire logic [11:0]      phase_u_current_ma,
	input  wire logic [7:0]       speed_est,
	input  wire logic [7:0]       bemf_sample,
	input  wire logic             open_loop,
	input  wire logic             closed_loop,
	input  wire logic             drive_above_handoff,
	input  wire logic             ol_to_cl_handoff,
	input  wire logic             elec_cycle_tick,
	input  wire logic             half_cycle_tick,
	input  wire logic             bemf_zero_cross,
	input  wire logic             commutation_tick,
	input  wire logic             vcc_at_upper,
	input  wire logic             fg_drive,
	input  wire logic [2:0][7:0]  phase_duty,
	// drive and status
	output logic      [2:0]       high_on,
	output logic      [2:0]       low_on,
	output logic                  phase_hiz,
	output logic                  restart_pulse,
	output logic                  speed_pulse_output,
	output logic      [7:0]       buffered_cmd
);

	//--------------------------------------------------------------------------
	// parameter checks
	//--------------------------------------------------------------------------
	if (LOCK_OFF_CYCLES < 1 || LOCK_OFF_CYCLES > 16777215) begin : g_chk_off
		$error("lock-off cycles out of range");
	end
	if (ABN_SPEED_CYCLES < 1 || ABN_SPEED_CYCLES > 65535) begin : g_chk_abn
		$error("abnormal speed cycles out of range");
	end

	typedef struct packed {
		motor_lock_pkg::fault_state_t st;
		logic [23:0] cnt;
		logic        locked;
		logic [5:0]  fault;
		logic        restart;
		logic        hiz;
		logic        brake;
		logic        fg;
		logic [7:0]  cmd_buf;
		logic [15:0] abn_cnt;
		logic [15:0] integ;
		logic [15:0] per_cnt;
		logic [15:0] per_prev;
		logic        ol_armed;
		logic        ol_seen;
		logic [18:0] ctrl;
		logic [23:0] motor;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] rdata;
	} sup_state_t;

	sup_state_t s_ff;
	sup_state_t nxt_s;

	//--------------------------------------------------------------------------
	// configuration fields
	//--------------------------------------------------------------------------
	logic [5:0]  lock_scheme_enable;
	logic        mechanical_surge_enable;
	logic        inductive_surge_enable;
	logic        mechanical_surge_mode;
	logic        pwm_rate_double;
	logic [3:0]  dead_code;
	logic [2:0]  lock_current_threshold;
	logic [6:0]  phase_resistance_setting;
	logic [6:0]  bemf_constant_setting;
	logic [7:0]  speed_cmd;

	assign lock_scheme_enable      = s_ff.ctrl[motor_lock_pkg::CTRL_EN_LSB +: 6];
	assign mechanical_surge_enable = s_ff.ctrl[motor_lock_pkg::CTRL_MECH_EN];
	assign inductive_surge_enable  = s_ff.ctrl[motor_lock_pkg::CTRL_IND_EN];
	assign mechanical_surge_mode   = s_ff.ctrl[motor_lock_pkg::CTRL_MECH_MODE];
	assign pwm_rate_double         = s_ff.ctrl[motor_lock_pkg::CTRL_DOUBLE];
	assign dead_code               = s_ff.ctrl[motor_lock_pkg::CTRL_DEAD_LSB +: 4];
	assign lock_current_threshold  = s_ff.ctrl[motor_lock_pkg::CTRL_ITHR_LSB +: 3];
	assign phase_resistance_setting = s_ff.motor[motor_lock_pkg::MOTOR_RM_LSB +: 7];
	assign bemf_constant_setting   = s_ff.motor[motor_lock_pkg::MOTOR_KT_LSB +: 7];
	assign speed_cmd               = s_ff.motor[motor_lock_pkg::MOTOR_CMD_LSB +: 8];

	//--------------------------------------------------------------------------
	// detection conditions
	//--------------------------------------------------------------------------
	logic [11:0] ithr_ma;
	logic [7:0]  bemf_spd;
	logic [7:0]  ir_drop;
	logic [7:0]  bemf_cur;
	logic [8:0]  amp_margin;
	logic        abn_now;
	logic [15:0] ktc_exp;
	logic [15:0] ktc_dev;
	logic [5:0]  raw;
	logic        trig;
	logic        clamp_on;

	assign ithr_ma = 12'((13'(lock_current_threshold) + 13'h0001)
	                     * 13'(motor_lock_pkg::LOCK_I_STEP_MA));
	assign bemf_spd = 8'((15'(speed_est) * 15'(bemf_constant_setting))
	                     >> motor_lock_pkg::BEMF_SHIFT);
	assign ir_drop = 8'((15'(phase_u_current_ma[11:4])
	                     * 15'(phase_resistance_setting))
	                    >> motor_lock_pkg::BEMF_SHIFT);
	assign bemf_cur = (s_ff.cmd_buf > ir_drop) ? s_ff.cmd_buf - ir_drop : 8'h00;
	assign amp_margin = 9'(s_ff.cmd_buf) + 9'(s_ff.cmd_buf[7:1]);
	assign abn_now = closed_loop && (9'(bemf_spd) > amp_margin)
	                 && (bemf_spd > bemf_cur);
	assign ktc_exp = {bemf_constant_setting, 9'h000};
	assign ktc_dev = (s_ff.integ > ktc_exp) ? s_ff.integ - ktc_exp
	                                        : ktc_exp - s_ff.integ;

	always_comb begin
		raw = 6'h00;
		raw[motor_lock_pkg::LK_OVERCURRENT] = lowside_current_ma > ithr_ma;
		raw[motor_lock_pkg::LK_ABN_SPEED] = abn_now
			&& (s_ff.abn_cnt == 16'(ABN_SPEED_CYCLES - 1));
		raw[motor_lock_pkg::LK_ABN_CONST] = closed_loop && half_cycle_tick
			&& (ktc_dev > {1'b0, ktc_exp[15:1]});
		raw[motor_lock_pkg::LK_NO_MOTOR] = ol_to_cl_handoff
			&& (phase_u_current_ma <= 12'(motor_lock_pkg::NO_MOTOR_MA));
		raw[motor_lock_pkg::LK_OL_STUCK] = open_loop && drive_above_handoff
			&& elec_cycle_tick && s_ff.ol_armed && !s_ff.ol_seen
			&& !bemf_zero_cross;
		raw[motor_lock_pkg::LK_CL_STUCK] = closed_loop
			&& (s_ff.per_prev != 16'h0000)
			&& (17'(s_ff.per_cnt) > {s_ff.per_prev, 1'b0});
	end

	assign trig = (s_ff.st == motor_lock_pkg::st_run)
	              && ((raw & lock_scheme_enable) != 6'h00);
	assign clamp_on = mechanical_surge_enable
	                  && (!mechanical_surge_mode || vcc_at_upper);

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------
	always_comb begin
		logic [7:0] ra;
		ra = 8'h00;
		nxt_s = s_ff;
		nxt_s.restart = 1'b0;

		// register writes in data phase
		if (s_ff.wr_pend) begin
			if (s_ff.wr_addr == motor_lock_pkg::REG_CTRL) begin
				nxt_s.ctrl = hwdata[motor_lock_pkg::CTRL_W-1:0];
			end else if (s_ff.wr_addr == motor_lock_pkg::REG_MOTOR) begin
				nxt_s.motor = hwdata[motor_lock_pkg::MOTOR_W-1:0];
			end
		end
		nxt_s.wr_pend = 1'b0;
		if (hsel && hready && htrans[1]) begin
			ra = {haddr[7:2], 2'b00};
			nxt_s.wr_pend = hwrite && (hsize == 3'b010);
			nxt_s.wr_addr = ra;
			nxt_s.rdata = 32'h00000000;
			if (!hwrite) begin
				if (ra == motor_lock_pkg::REG_CTRL) begin
					nxt_s.rdata = 32'(nxt_s.ctrl);
				end else if (ra == motor_lock_pkg::REG_MOTOR) begin
					nxt_s.rdata = 32'(nxt_s.motor);
				end else if (ra == motor_lock_pkg::REG_STATUS) begin
					nxt_s.rdata = {s_ff.cmd_buf, 6'h00, 2'(s_ff.st), 2'h0,
					               s_ff.fault, 7'h00, s_ff.locked};
				end
			end
		end

		// abnormal speed persistence
		nxt_s.abn_cnt = abn_now ? s_ff.abn_cnt + 16'h0001 : 16'h0000;
		if (raw[motor_lock_pkg::LK_ABN_SPEED]) begin
			nxt_s.abn_cnt = 16'h0000;
		end

		// half-cycle bemf integral
		if (!closed_loop || half_cycle_tick) begin
			nxt_s.integ = 16'h0000;
		end else if (s_ff.integ <= 16'hffff - 16'(bemf_sample)) begin
			nxt_s.integ = s_ff.integ + 16'(bemf_sample);
		end

		// commutation period
		if (!closed_loop) begin
			nxt_s.per_cnt = 16'h0000;
			nxt_s.per_prev = 16'h0000;
		end else if (commutation_tick) begin
			nxt_s.per_prev = s_ff.per_cnt;
			nxt_s.per_cnt = 16'h0000;
		end else if (s_ff.per_cnt != 16'hffff) begin
			nxt_s.per_cnt = s_ff.per_cnt + 16'h0001;
		end

		// open loop stuck watch
		if (!(open_loop && drive_above_handoff)) begin
			nxt_s.ol_armed = 1'b0;
			nxt_s.ol_seen = 1'b0;
		end else if (elec_cycle_tick) begin
			nxt_s.ol_armed = 1'b1;
			nxt_s.ol_seen = bemf_zero_cross;
		end else if (bemf_zero_cross) begin
			nxt_s.ol_seen = 1'b1;
		end

		// fault sequence
		unique case (s_ff.st)
			motor_lock_pkg::st_run: begin
				if (trig) begin
					nxt_s.st = motor_lock_pkg::st_surge;
					nxt_s.hiz = 1'b1;
					nxt_s.locked = 1'b1;
					nxt_s.brake = inductive_surge_enable;
					nxt_s.cnt = inductive_surge_enable
						? 24'(motor_lock_pkg::AVS_IND_CYCLES - 1) : 24'h000000;
				end
			end
			motor_lock_pkg::st_surge: begin
				if (s_ff.cnt == 24'h000000) begin
					nxt_s.st = motor_lock_pkg::st_off;
					nxt_s.brake = 1'b0;
					nxt_s.cnt = 24'(LOCK_OFF_CYCLES - 1);
				end else begin
					nxt_s.cnt = s_ff.cnt - 24'h000001;
				end
			end
			motor_lock_pkg::st_off: begin
				if (s_ff.cnt == 24'h000000) begin
					nxt_s.st = motor_lock_pkg::st_run;
					nxt_s.hiz = 1'b0;
					nxt_s.locked = 1'b0;
					nxt_s.restart = 1'b1;
				end else begin
					nxt_s.cnt = s_ff.cnt - 24'h000001;
				end
			end
		endcase

		// source bits: a new event wins over the restart clear
		nxt_s.fault = (nxt_s.restart ? 6'h00 : s_ff.fault) | raw;

		// mechanical surge clamp on the buffered command
		nxt_s.cmd_buf = (clamp_on && (speed_cmd < bemf_spd))
			? bemf_spd : speed_cmd;

		// speed pulse forced high while locked
		nxt_s.fg = nxt_s.locked ? 1'b1 : fg_drive;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
			s_ff.st <= motor_lock_pkg::st_run;
			s_ff.ctrl <= motor_lock_pkg::CTRL_RST;
			s_ff.motor <= motor_lock_pkg::MOTOR_RST;
			s_ff.fg <= 1'b1;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	//--------------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------------
	assign hreadyout          = ce;
	assign hresp              = 1'b0;
	assign hrdata             = s_ff.rdata;
	assign phase_hiz          = s_ff.hiz;
	assign restart_pulse      = s_ff.restart;
	assign speed_pulse_output = s_ff.fg;
	assign buffered_cmd       = s_ff.cmd_buf;

	pwm_dead_time_bridge u_pwm (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ce          (ce),
		.rate_double (pwm_rate_double),
		.dead_code   (dead_code),
		.amplitude   (s_ff.cmd_buf),
		.phase_duty  (phase_duty),
		.hiz         (s_ff.hiz),
		.brake       (s_ff.brake),
		.high_on     (high_on),
		.low_on      (low_on)
	);

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_lock_to_hiz: assert property (ce && trig |=> phase_hiz && s_ff.locked)
		else $error("lock did not tri-state outputs");
	a_enable_gates: assert property (
		ce && !phase_hiz && ((raw & lock_scheme_enable) == 6'h00) |=> !phase_hiz)
		else $error("disabled scheme tripped the drive");
	a_flag_set: assert property (ce && trig |=> s_ff.locked)
		else $error("locked flag not set");
	a_source_kept: assert property (
		ce && !nxt_s.restart |=> (s_ff.fault & $past(raw)) == $past(raw))
		else $error("fault source bit missing");
	a_restart_clr: assert property (
		ce && nxt_s.restart && raw == 6'h00 |=> s_ff.fault == 6'h00)
		else $error("fault bits not cleared at restart");
	a_surge_entry: assert property (
		$rose(phase_hiz) |-> s_ff.st == motor_lock_pkg::st_surge
		&& s_ff.brake == inductive_surge_enable)
		else $error("surge sequence skipped");
	a_retry_after: assert property (
		ce && s_ff.st == motor_lock_pkg::st_off && s_ff.cnt == 24'h000000
		|=> restart_pulse && !phase_hiz)
		else $error("no restart after lock-off");
	a_clamp_floor: assert property (
		ce && clamp_on |=> buffered_cmd >= $past(bemf_spd))
		else $error("command below bemf under clamp");
	a_regen_mode: assert property (
		ce && mechanical_surge_enable && mechanical_surge_mode && !vcc_at_upper
		|=> buffered_cmd == $past(speed_cmd))
		else $error("clamp active below upper supply");
	a_fg_high: assert property (s_ff.locked |-> speed_pulse_output)
		else $error("speed pulse low while locked");
	a_ocp_trip: assert property (
		ce && !phase_hiz && lock_scheme_enable[0]
		&& lowside_current_ma > ithr_ma |=> phase_hiz)
		else $error("overcurrent did not trip");

	c_lock_retry: cover property ($fell(phase_hiz) && restart_pulse);
	c_no_motor: cover property (raw[motor_lock_pkg::LK_NO_MOTOR] && trig);
	c_clamp: cover property (clamp_on && speed_cmd < bemf_spd);

endmodule // motor_lock_fault_supervisor

// ==== motor_lock_fault_supervisor_tb_top.sv ====
// Purpose: self-checking bench for the motor lock supervisor
// Assumes: ce held high, zero wait state bus
// Notes:   lock-off shortened to 20 cycles
`timescale 1ns/1ps
module motor_lock_fault_supervisor_tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic hready, hreadyout, hresp, phase_hiz, restart_pulse;
	logic speed_pulse_output, rotor_jam = 1'b0, unplugged = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = 2'b00;
	logic [2:0] hsize = 3'b010, high_on, low_on;
	logic [11:0] lowside_current_ma, phase_u_current_ma;
	logic [7:0] speed_est = 8'h00, bemf_sample = 8'h00;
	logic [7:0] buffered_cmd;
	logic open_loop = 1'b0, closed_loop = 1'b0, drive_above_handoff = 1'b0;
	logic ol_to_cl_handoff = 1'b0, elec_cycle_tick = 1'b0;
	logic half_cycle_tick = 1'b0, bemf_zero_cross = 1'b0;
	logic commutation_tick = 1'b0, vcc_at_upper = 1'b0, fg_drive = 1'b0;
	logic [2:0][7:0] phase_duty = '0;
	int err_total = 0, cmp_count = 0, n;
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	motor_lock_fault_supervisor #(.LOCK_OFF_CYCLES(20), .ABN_SPEED_CYCLES(4))
	motor_lock_fault_supervisor_inst (.hclk, .hresetn, .ce, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
		.hrdata, .lowside_current_ma, .phase_u_current_ma, .speed_est,
		.bemf_sample, .open_loop, .closed_loop, .drive_above_handoff,
		.ol_to_cl_handoff, .elec_cycle_tick, .half_cycle_tick,
		.bemf_zero_cross, .commutation_tick, .vcc_at_upper, .fg_drive,
		.phase_duty, .high_on, .low_on, .phase_hiz, .restart_pulse,
		.speed_pulse_output, .buffered_cmd);
	motor_phase_model motor_phase_model_inst (.hclk, .rotor_jam, .unplugged,
		.phase_hiz, .lowside_current_ma, .phase_u_current_ma);
	//--------------------------------------------------------------------
	// shared tasks
	//--------------------------------------------------------------------
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_rdy;
		int k;
		k = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 50) begin
				err_total++;
				test_done;
			end
			@(posedge hclk);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_rdy;
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: pick = phase_hiz;
			1: pick = restart_pulse;
			2: pick = high_on[0];
			default: pick = low_on[0];
		endcase
	endfunction
	task automatic wait_on(input int w, input logic v);
		n = 0;
		while (pick(w) !== v) begin
			n++;
			if (n > 1000) begin
				err_total++;
				test_done;
			end
			@(posedge hclk);
		end
	endtask
	//--------------------------------------------------------------------
	// scenarios
	//--------------------------------------------------------------------
	task automatic test_regs;
		bus(0, 8'h00, 0);
		check(rd, 32'h0000033f);
		check(hresp, 1'b0);
		bus(1, 8'h00, 32'h0000933f);
		bus(0, 8'h00, 0);
		check(rd, 32'h0000933f);
		bus(1, 8'h04, 32'h12345678);
		bus(0, 8'h04, 0);
		check(rd, 32'h00345678);
		bus(0, 8'h0c, 0);
		check(rd, 32'h0);
		$display("test regs done");
	endtask
	task automatic test_overcurrent;
		rotor_jam <= 1'b1;
		wait_on(0, 1'b1);
		rotor_jam <= 1'b0;
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h0101);
		check({high_on, low_on}, 6'h07);
		check(speed_pulse_output, 1'b1);
		wait_on(1, 1'b1);
		check(n >= 33 && n <= 35, 1'b1);
		@(posedge hclk);
		check(phase_hiz, 1'b0);
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h0);
		$display("test overcurrent done");
	endtask
	task automatic test_no_motor;
		unplugged <= 1'b1;
		@(posedge hclk);
		ol_to_cl_handoff <= 1'b1;
		@(posedge hclk);
		ol_to_cl_handoff <= 1'b0;
		wait_on(0, 1'b1);
		unplugged <= 1'b0;
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h0801);
		check(phase_hiz, 1'b1);
		wait_on(1, 1'b1);
		@(posedge hclk);
		$display("test no motor done");
	endtask
	task automatic test_clamp;
		speed_est <= 8'hff;
		repeat (2) @(posedge hclk);
		check(buffered_cmd, 8'hab);
		bus(1, 8'h00, 32'h0000973f);
		repeat (2) @(posedge hclk);
		check(buffered_cmd, 8'h34);
		vcc_at_upper <= 1'b1;
		repeat (2) @(posedge hclk);
		check(buffered_cmd, 8'hab);
		speed_est <= 8'h00;
		vcc_at_upper <= 1'b0;
		bus(1, 8'h00, 32'h0000933f);
		repeat (2) @(posedge hclk);
		check(buffered_cmd, 8'h34);
		$display("test clamp done");
	endtask
	task automatic test_stuck;
		closed_loop <= 1'b1;
		repeat (2) @(posedge hclk);
		commutation_tick <= 1'b1;
		@(posedge hclk);
		commutation_tick <= 1'b0;
		repeat (3) @(posedge hclk);
		commutation_tick <= 1'b1;
		@(posedge hclk);
		commutation_tick <= 1'b0;
		wait_on(0, 1'b1);
		closed_loop <= 1'b0;
		check(n, 9);
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h2001);
		wait_on(1, 1'b1);
		open_loop <= 1'b1;
		drive_above_handoff <= 1'b1;
		@(posedge hclk);
		elec_cycle_tick <= 1'b1;
		@(posedge hclk);
		elec_cycle_tick <= 1'b0;
		repeat (3) @(posedge hclk);
		elec_cycle_tick <= 1'b1;
		@(posedge hclk);
		elec_cycle_tick <= 1'b0;
		wait_on(0, 1'b1);
		open_loop <= 1'b0;
		drive_above_handoff <= 1'b0;
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h1001);
		wait_on(1, 1'b1);
		@(posedge hclk);
		$display("test stuck done");
	endtask
	task automatic pwm_period(output int d, output int t);
		wait_on(2, 1'b1);
		wait_on(2, 1'b0);
		wait_on(3, 1'b1);
		d = n;
		t = n;
		wait_on(2, 1'b1);
		t += n;
		wait_on(2, 1'b0);
		t += n;
	endtask
	task automatic test_pwm;
		int d, t;
		phase_duty[0] <= 8'h80;
		pwm_period(d, t);
		check(d, 4);
		check(t, 400);
		bus(1, 8'h00, 32'h00009b3f);
		pwm_period(d, t);
		check(t, 200);
		check(d, 4);
		bus(1, 8'h00, 32'h0000933f);
		phase_duty[0] <= 8'h00;
		$display("test pwm done");
	endtask
	task automatic test_disabled;
		bus(1, 8'h00, 32'h0000933e);
		rotor_jam <= 1'b1;
		repeat (6) @(posedge hclk);
		rotor_jam <= 1'b0;
		check(phase_hiz, 1'b0);
		bus(0, 8'h08, 0);
		check(rd & 32'h3f01, 32'h0100);
		$display("test disabled done");
	endtask
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		test_regs;
		test_overcurrent;
		test_no_motor;
		test_clamp;
		test_stuck;
		test_pwm;
		test_disabled;
		test_done;
	end
endmodule // motor_lock_fault_supervisor_tb_top

// ==== motor_lock_pkg.sv ====
//------------------------------------------------------------------------------
// Purpose: shared constants and types for the motor lock supervisor
// Assumes: 10 MHz hclk, 32-bit word registers
// Notes:   offsets are byte addresses
//------------------------------------------------------------------------------
package motor_lock_pkg;

	//--------------------------------------------------------------------------
	// clock and timing
	//--------------------------------------------------------------------------
	localparam int CLK_HZ          = 10_000_000;
	localparam int CLK_NS          = 100;
	localparam int PWM_BASE_HZ     = 25_000;
	localparam int PWM_PERIOD_SLOW = CLK_HZ / PWM_BASE_HZ;
	localparam int PWM_PERIOD_FAST = CLK_HZ / (2 * PWM_BASE_HZ);
	localparam int DEAD_STEP_NS    = 40;
	localparam int LOCK_OFF_DEF    = 5_000_000;
	localparam int ABN_SPEED_DEF   = 2_000;
	localparam int AVS_IND_CYCLES  = 16;

	//--------------------------------------------------------------------------
	// thresholds and scaling
	//--------------------------------------------------------------------------
	localparam int NO_MOTOR_MA    = 140;
	localparam int LOCK_I_STEP_MA = 400;
	localparam int BEMF_SHIFT     = 7;
	localparam int KTC_SHIFT      = 9;

	//--------------------------------------------------------------------------
	// register map
	//--------------------------------------------------------------------------
	localparam logic [7:0]  REG_CTRL   = 8'h00;
	localparam logic [7:0]  REG_MOTOR  = 8'h04;
	localparam logic [7:0]  REG_STATUS = 8'h08;
	localparam int          CTRL_W     = 19;
	localparam int          MOTOR_W    = 24;
	localparam logic [18:0] CTRL_RST   = 19'h0033f;
	localparam logic [23:0] MOTOR_RST  = 24'h000000;
	localparam int CTRL_EN_LSB    = 0;
	localparam int CTRL_MECH_EN   = 8;
	localparam int CTRL_IND_EN    = 9;
	localparam int CTRL_MECH_MODE = 10;
	localparam int CTRL_DOUBLE    = 11;
	localparam int CTRL_DEAD_LSB  = 12;
	localparam int CTRL_ITHR_LSB  = 16;
	localparam int MOTOR_RM_LSB   = 0;
	localparam int MOTOR_KT_LSB   = 8;
	localparam int MOTOR_CMD_LSB  = 16;

	//--------------------------------------------------------------------------
	// detection schemes and states
	//--------------------------------------------------------------------------
	localparam int LK_OVERCURRENT = 0;
	localparam int LK_ABN_SPEED   = 1;
	localparam int LK_ABN_CONST   = 2;
	localparam int LK_NO_MOTOR    = 3;
	localparam int LK_OL_STUCK    = 4;
	localparam int LK_CL_STUCK    = 5;

	typedef enum logic [1:0] {st_run, st_surge, st_off} fault_state_t;

endpackage

// ==== motor_phase_model.sv ====
// Purpose: motor windings and current sense behind the supervisor
// Assumes: currents in mA, updated on hclk
// Notes:   no current flows while phases are high impedance
`timescale 1ns/1ps
module motor_phase_model (
	// clock
	input  wire logic        hclk,
	// scenario controls
	input  wire logic        rotor_jam,
	input  wire logic        unplugged,
	input  wire logic        phase_hiz,
	// current sense
	output logic      [11:0] lowside_current_ma,
	output logic      [11:0] phase_u_current_ma
);
	initial begin
		lowside_current_ma = 12'h000;
		phase_u_current_ma = 12'h000;
	end
	// jam draws 600 mA, free run 200 mA
	always @(posedge hclk) begin
		lowside_current_ma <= (phase_hiz || unplugged) ? 12'h000 :
			(rotor_jam ? 12'h258 : 12'h0c8);
		phase_u_current_ma <= (phase_hiz || unplugged) ? 12'h000 : 12'h0c8;
	end
endmodule // motor_phase_model

// ==== pwm_dead_time_bridge.sv ====
//------------------------------------------------------------------------------
// Purpose: three-leg pwm with dead time and high-impedance override
// Assumes: hclk at 10 MHz, duty and amplitude 8-bit
// Notes:   brake turns all low sides on while high impedance is held
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module pwm_dead_time_bridge (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	// configuration
	input  wire logic             rate_double,
	input  wire logic [3:0]       dead_code,
	input  wire logic [7:0]       amplitude,
	input  wire logic [2:0][7:0]  phase_duty,
	input  wire logic             hiz,
	input  wire logic             brake,
	// gate drive
	output logic      [2:0]       high_on,
	output logic      [2:0]       low_on
);

	typedef struct packed {
		logic [8:0]      cnt;
		logic [2:0]      want;
		logic [2:0][2:0] dead;
		logic [2:0]      hs;
		logic [2:0]      ls;
	} pwm_state_t;

	pwm_state_t s_ff;
	pwm_state_t nxt_s;
	logic [8:0] per;
	logic [2:0] dead_cyc;

	//--------------------------------------------------------------------------
	// period and dead time
	//--------------------------------------------------------------------------
	assign per = rate_double ? 9'(motor_lock_pkg::PWM_PERIOD_FAST) :
	                           9'(motor_lock_pkg::PWM_PERIOD_SLOW);
	assign dead_cyc = 3'(((int'(dead_code) + 1) * motor_lock_pkg::DEAD_STEP_NS
	                      + motor_lock_pkg::CLK_NS - 1)
	                     / motor_lock_pkg::CLK_NS);

	//--------------------------------------------------------------------------
	// next state
	//--------------------------------------------------------------------------
	always_comb begin
		logic [7:0] lvl;
		logic       w;
		lvl = 8'h00;
		w = 1'b0;
		nxt_s = s_ff;
		nxt_s.cnt = (s_ff.cnt >= per - 9'h001) ? 9'h000 : s_ff.cnt + 9'h001;
		for (int i = 0; i < 3; i++) begin
			lvl = 8'((16'(amplitude) * 16'(phase_duty[i])) >> 8);
			w = {s_ff.cnt, 8'h00} < 17'(17'(lvl) * 17'(per));
			if (hiz) begin
				nxt_s.want[i] = 1'b0;
				nxt_s.dead[i] = 3'h0;
				nxt_s.hs[i] = 1'b0;
				nxt_s.ls[i] = brake;
			end else if (w != s_ff.want[i]) begin
				nxt_s.want[i] = w;
				nxt_s.dead[i] = dead_cyc - 3'h1;
				nxt_s.hs[i] = 1'b0;
				nxt_s.ls[i] = 1'b0;
			end else if (s_ff.dead[i] != 3'h0) begin
				nxt_s.dead[i] = s_ff.dead[i] - 3'h1;
				nxt_s.hs[i] = 1'b0;
				nxt_s.ls[i] = 1'b0;
			end else begin
				nxt_s.hs[i] = s_ff.want[i];
				nxt_s.ls[i] = ~s_ff.want[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_ff <= '0;
		end else if (ce) begin
			s_ff <= nxt_s;
		end
	end

	assign high_on = s_ff.hs;
	assign low_on  = s_ff.ls;

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------
	a_no_shoot: assert property (@(posedge hclk) disable iff (!hresetn)
		(high_on & low_on) == 3'b000)
		else $error("high and low side on together");

endmodule // pwm_dead_time_bridge
